// ### smbcfg_host_model.sv
// SMBus host model for the configuration target bench
`timescale 1ns/1ps
`default_nettype none
module smbcfg_host_model
(
	// Time base
	input  wire logic	i_core_clk,
	// Bus wires
	input  wire logic	i_sda,
	output var logic	o_scl,
	output var logic	o_sda_oe
);
	int	slow_cycles = 0;
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task quarter();
		repeat (4) @(negedge i_core_clk);
	endtask : quarter
	// Start or repeated start, ends with clock low
	task start_cond();
		quarter();
		o_sda_oe = 1'b0;
		quarter();
		o_scl = 1'b1;
		quarter();
		o_sda_oe = 1'b1;
		quarter();
		o_scl = 1'b0;
	endtask : start_cond
	// Stop after any whole byte
	task stop_cond();
		quarter();
		o_sda_oe = 1'b1;
		quarter();
		o_scl = 1'b1;
		quarter();
		o_sda_oe = 1'b0;
		quarter();
	endtask : stop_cond
	// One bit, low phase stretched when slow
	task bit_io(input logic b, output logic r);
		repeat (slow_cycles) @(negedge i_core_clk);
		quarter();
		o_sda_oe = ~b;
		quarter();
		o_scl = 1'b1;
		quarter();
		r = i_sda;
		quarter();
		o_scl = 1'b0;
	endtask : bit_io
	task send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send_byte
	task recv_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask : recv_byte
endmodule : smbcfg_host_model
`default_nettype wire

// ### smbcfg_pkg.sv
// Constants and types for the SMBus configuration target
`default_nettype none
package smbcfg_pkg;

	// Byte offsets of the configuration bank
	localparam logic [6:0] OFS_REV_VENDOR  = 7'h00;
	localparam logic [6:0] OFS_PLL1_REF    = 7'h01;
	localparam logic [6:0] OFS_PLL1_FB     = 7'h02;
	localparam logic [6:0] OFS_MUX_PLL1_HI = 7'h03;
	localparam logic [6:0] OFS_PLL2_REF    = 7'h04;
	localparam logic [6:0] OFS_PLL2_FB     = 7'h05;
	localparam logic [6:0] OFS_VCO_PLL2_HI = 7'h06;
	localparam logic [6:0] OFS_PLL3_REF    = 7'h07;
	localparam logic [6:0] OFS_PLL3_FB     = 7'h08;
	localparam logic [6:0] OFS_POST0_HI    = 7'h09;
	localparam logic [6:0] OFS_POST1_CFG   = 7'h0a;
	localparam logic [6:0] OFS_SRC_POST23  = 7'h0b;
	localparam logic [6:0] OFS_PD_POST45   = 7'h0c;
	localparam logic [6:0] OFS_STATUS      = 7'h18;
	localparam int         LAST_CFG        = 12;
	localparam int         NVM_BYTES       = 13;

	// Field positions
	localparam int CMD_SINGLE_BIT   = 7;
	localparam int STATUS_BUSY_BIT  = 7;
	localparam int PD_RESERVED_BIT  = 7;

	// Bus address, upper five bits fixed
	localparam logic [4:0] ADDR_UPPER = 5'h1a;

	// Values after reset
	localparam logic [7:0] RST_PLL1_REF    = 8'h01;
	localparam logic [7:0] RST_PLL1_FB     = 8'h08;
	localparam logic [7:0] RST_MUX_PLL1_HI = 8'h00;
	localparam logic [7:0] RST_PLL2_REF    = 8'h1b;
	localparam logic [7:0] RST_PLL2_FB     = 8'h1b;
	localparam logic [7:0] RST_VCO_PLL2_HI = 8'h00;
	localparam logic [7:0] RST_PLL3_REF    = 8'h77;
	localparam logic [7:0] RST_PLL3_FB     = 8'h77;
	localparam logic [7:0] RST_POST0_HI    = 8'h03;
	localparam logic [7:0] RST_POST1_CFG   = 8'h01;
	localparam logic [7:0] RST_SRC_POST23  = 8'h00;
	localparam logic [7:0] RST_PD_POST45   = 8'h00;

	// Nonvolatile programming time
	localparam int CLK_PERIOD_NS   = 10;
	localparam int NVM_PROG_US     = 10;
	localparam int NVM_PROG_CYCLES = (NVM_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] NVM_PROG_CNT = 16'(NVM_PROG_CYCLES);

	typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} smbcfg_state_t;
	typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_COUNT, PH_DATA} smbcfg_phase_t;

endpackage : smbcfg_pkg
`default_nettype wire

// ### smbcfg_target.sv
// SMBus configuration target with byte bank and nonvolatile copy
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Serve byte write, byte read, block write and block read.
// - Block bytes move in rising offset order, msb first.
// - Host may stop a block after any whole byte.
// - Single-byte access touches only the one addressed byte.
// - A written byte takes effect at its acknowledge rising edge.
// - Starting nonvolatile programming copies the bank to the store.
// - Reads are still served while programming runs.
// - Programming-in-progress flag reads at byte 24 bit 7.
// - Respond to seven-bit address with upper bits 11010.
// - Low address bits come from byte 10 configuration fields.
// - Command bit 7 picks block (0) or single byte (1).
// - Command bits 6 to 0 give the starting offset.
// - Bank loads defaults at reset, device works unprogrammed.
// - Byte 0 holds revision high nibble and vendor low nibble.
// - Reference dividers are 9 bits, ninth bit in shared byte bit 0.
// - Feedback dividers are 12 bits, upper four in shared byte bits 4:1.
// - Six post-divider source fields of 3 bits in bytes 9 to 12.
module smbcfg_target
#(
	parameter logic [3:0] REVISION   = 4'h0,
	parameter logic [3:0] VENDOR_ID  = 4'h5,  // Arbitrary value
	parameter logic [7:0] BLOCK_SIZE = 8'h0d
)
(
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rstn,
	// Serial pins
	input  wire logic                  i_serial_clk_pin,
	input  wire logic                  i_serial_data_pin,
	output logic                       o_serial_data_pin,
	output logic                       o_serial_data_pin_oe,
	// Nonvolatile copy
	input  wire logic                  i_nvm_start,
	output logic                       o_nvm_wr_en,
	output logic [6:0]                 o_nvm_wr_addr,
	output logic [7:0]                 o_nvm_wr_data,
	output logic                       o_nvm_write_in_progress,
	// Configuration
	output logic [8:0]                 o_pll1_ref_div,
	output logic [8:0]                 o_pll2_ref_div,
	output logic [8:0]                 o_pll3_ref_div,
	output logic [11:0]                o_pll1_fb_div,
	output logic [11:0]                o_pll2_fb_div,
	output logic [11:0]                o_pll3_fb_div,
	output logic [2:0]                 o_pll_mux_sel,
	output logic [2:0]                 o_vco_range_sel,
	output logic [5:0][2:0]            o_post_source,
	output logic [1:0]                 o_config_input_zero,
	output logic [1:0]                 o_config_input_one,
	output logic                       o_input_clock_sel,
	output logic [1:0]                 o_input_signal_source,
	output logic                       o_power_down
);
	import smbcfg_pkg::*;

	logic [2:0]    scl_sync_reg;
	logic [2:0]    sda_sync_reg;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_det;
	logic          stop_det;
	smbcfg_state_t st_reg;
	smbcfg_phase_t phase_reg;
	logic [3:0]    cnt_reg;
	logic [7:0]    shift_reg;
	logic [7:0]    tx_reg;
	logic          sda_oe_reg;
	logic          rw_reg;
	logic          single_reg;
	logic          single_done_reg;
	logic          master_ack_reg;
	logic [6:0]    ptr_reg;
	logic [7:0]    cfg_reg [1:LAST_CFG];
	logic          nvm_busy_reg;
	logic          nvm_copy_reg;
	logic [6:0]    nvm_idx_reg;
	logic [15:0]   nvm_wait_reg;
	logic          nvm_wr_en_reg;
	logic [6:0]    nvm_addr_reg;
	logic [7:0]    nvm_data_reg;
	logic [6:0]    own_addr;
	logic          addr_hit;
	logic          byte_done;
	logic          ack_now;
	logic          wr_fire;
	logic          nvm_go;
	logic [7:0]    rd_cur;
	logic [7:0]    rd_nxt;

	// Read view of one offset
	function automatic logic [7:0] rd_byte(input logic [6:0] ofs);
		logic [7:0] val;
		val = 8'h00;
		if (ofs == OFS_REV_VENDOR)
			val = {REVISION, VENDOR_ID};
		else if (ofs <= 7'(LAST_CFG))
			val = cfg_reg[ofs];
		else if (ofs == OFS_STATUS)
			val = {nvm_busy_reg, 7'h00};
		return val;
	endfunction : rd_byte

	// Two-flop synchronisers plus one history flop for edges
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[1:0], i_serial_clk_pin};
			sda_sync_reg <= {sda_sync_reg[1:0], i_serial_data_pin};
		end
	end

	assign scl_rise  = scl_sync_reg[1] && !scl_sync_reg[2];
	assign scl_fall  = !scl_sync_reg[1] && scl_sync_reg[2];
	assign start_det = scl_sync_reg[1] && scl_sync_reg[2] && sda_sync_reg[2] && !sda_sync_reg[1];
	assign stop_det  = scl_sync_reg[1] && scl_sync_reg[2] && !sda_sync_reg[2] && sda_sync_reg[1];

	assign own_addr  = {ADDR_UPPER, cfg_reg[10][2], cfg_reg[10][0]};
	assign addr_hit  = shift_reg[7:1] == own_addr;
	assign byte_done = scl_fall && (st_reg == S_RX) && (cnt_reg == 4'h8);
	assign wr_fire   = scl_rise && (st_reg == S_RX_ACK) && (phase_reg == PH_DATA) && !rw_reg;
	assign rd_cur    = rd_byte(ptr_reg);
	assign rd_nxt    = rd_byte(ptr_reg + 7'h1);

	// Acknowledge decision for a received byte
	always_comb
	begin
		ack_now = 1'b1;
		unique case (phase_reg)
			PH_ADDR:  ack_now = addr_hit;
			PH_CMD:   ack_now = 1'b1;
			PH_COUNT: ack_now = 1'b1;
			PH_DATA:  ack_now = !nvm_busy_reg && !(single_reg && single_done_reg);
		endcase
	end

	// Bus protocol engine
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			st_reg          <= S_IDLE;
			phase_reg       <= PH_ADDR;
			cnt_reg         <= 4'h0;
			shift_reg       <= 8'h00;
			tx_reg          <= 8'h00;
			sda_oe_reg      <= 1'b0;
			rw_reg          <= 1'b0;
			single_reg      <= 1'b0;
			single_done_reg <= 1'b0;
			master_ack_reg  <= 1'b0;
			ptr_reg         <= 7'h00;
		end
		else if (start_det)
		begin
			st_reg     <= S_RX;
			phase_reg  <= PH_ADDR;
			cnt_reg    <= 4'h0;
			sda_oe_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			st_reg     <= S_IDLE;
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			unique case (st_reg)
				S_IDLE:
				begin
					sda_oe_reg <= 1'b0;
				end
				S_RX:
				begin
					if (scl_rise && cnt_reg != 4'h8)
					begin
						shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
						cnt_reg   <= cnt_reg + 4'h1;
					end
					else if (byte_done)
					begin
						sda_oe_reg <= ack_now;
						st_reg     <= ack_now ? S_RX_ACK : S_IDLE;
					end
				end
				S_RX_ACK:
				begin
					if (wr_fire)
					begin
						single_done_reg <= 1'b1;
						if (!single_reg)
							ptr_reg <= ptr_reg + 7'h1;
					end
					else if (scl_fall)
					begin
						cnt_reg    <= 4'h0;
						sda_oe_reg <= 1'b0;
						st_reg     <= S_RX;
						unique case (phase_reg)
							PH_ADDR:
							begin
								rw_reg <= shift_reg[0];
								if (shift_reg[0])
								begin
									// Read: first bit goes out on this fall
									st_reg     <= S_TX;
									phase_reg  <= single_reg ? PH_DATA : PH_COUNT;
									tx_reg     <= single_reg ? rd_cur : BLOCK_SIZE;
									sda_oe_reg <= single_reg ? !rd_cur[7] : !BLOCK_SIZE[7];
								end
								else
									phase_reg <= PH_CMD;
							end
							PH_CMD:
							begin
								single_reg      <= shift_reg[CMD_SINGLE_BIT];
								ptr_reg         <= shift_reg[6:0];
								single_done_reg <= 1'b0;
								phase_reg       <= shift_reg[CMD_SINGLE_BIT] ? PH_DATA : PH_COUNT;
							end
							PH_COUNT:
								phase_reg <= PH_DATA;
							PH_DATA:
								phase_reg <= PH_DATA;
						endcase
					end
				end
				S_TX:
				begin
					if (scl_fall)
					begin
						if (cnt_reg == 4'h7)
						begin
							st_reg     <= S_TX_ACK;
							sda_oe_reg <= 1'b0;
						end
						else
						begin
							tx_reg     <= {tx_reg[6:0], 1'b0};
							sda_oe_reg <= !tx_reg[6];
							cnt_reg    <= cnt_reg + 4'h1;
						end
					end
				end
				S_TX_ACK:
				begin
					if (scl_rise)
						master_ack_reg <= !sda_sync_reg[1];
					else if (scl_fall)
					begin
						cnt_reg <= 4'h0;
						if (!master_ack_reg)
							st_reg <= S_IDLE;
						else if (phase_reg == PH_COUNT)
						begin
							st_reg     <= S_TX;
							phase_reg  <= PH_DATA;
							tx_reg     <= rd_cur;
							sda_oe_reg <= !rd_cur[7];
						end
						else if (single_reg)
						begin
							// Single read repeats the same byte, never the next
							st_reg     <= S_TX;
							tx_reg     <= rd_cur;
							sda_oe_reg <= !rd_cur[7];
						end
						else
						begin
							st_reg     <= S_TX;
							ptr_reg    <= ptr_reg + 7'h1;
							tx_reg     <= rd_nxt;
							sda_oe_reg <= !rd_nxt[7];
						end
					end
				end
			endcase
		end
	end

	assign o_serial_data_pin    = 1'b0;
	assign o_serial_data_pin_oe = sda_oe_reg;

	// Configuration bank, written at the acknowledge rising edge
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			cfg_reg[1]  <= RST_PLL1_REF;
			cfg_reg[2]  <= RST_PLL1_FB;
			cfg_reg[3]  <= RST_MUX_PLL1_HI;
			cfg_reg[4]  <= RST_PLL2_REF;
			cfg_reg[5]  <= RST_PLL2_FB;
			cfg_reg[6]  <= RST_VCO_PLL2_HI;
			cfg_reg[7]  <= RST_PLL3_REF;
			cfg_reg[8]  <= RST_PLL3_FB;
			cfg_reg[9]  <= RST_POST0_HI;
			cfg_reg[10] <= RST_POST1_CFG;
			cfg_reg[11] <= RST_SRC_POST23;
			cfg_reg[12] <= RST_PD_POST45;
		end
		else if (wr_fire && ptr_reg != OFS_REV_VENDOR && ptr_reg <= 7'(LAST_CFG))
		begin
			cfg_reg[ptr_reg] <= shift_reg;
			if (ptr_reg == OFS_PD_POST45)
				cfg_reg[ptr_reg][PD_RESERVED_BIT] <= 1'b0;
		end
	end

	// Field outputs
	assign o_pll1_ref_div        = {cfg_reg[3][0], cfg_reg[1]};
	assign o_pll2_ref_div        = {cfg_reg[6][0], cfg_reg[4]};
	assign o_pll3_ref_div        = {cfg_reg[9][0], cfg_reg[7]};
	assign o_pll1_fb_div         = {cfg_reg[3][4:1], cfg_reg[2]};
	assign o_pll2_fb_div         = {cfg_reg[6][4:1], cfg_reg[5]};
	assign o_pll3_fb_div         = {cfg_reg[9][4:1], cfg_reg[8]};
	assign o_pll_mux_sel         = cfg_reg[3][7:5];
	assign o_vco_range_sel       = cfg_reg[6][7:5];
	assign o_post_source[0]      = cfg_reg[9][7:5];
	assign o_post_source[1]      = cfg_reg[10][7:5];
	assign o_post_source[2]      = cfg_reg[11][2:0];
	assign o_post_source[3]      = cfg_reg[11][5:3];
	assign o_post_source[4]      = cfg_reg[12][2:0];
	assign o_post_source[5]      = cfg_reg[12][5:3];
	assign o_config_input_zero   = cfg_reg[10][1:0];
	assign o_config_input_one    = cfg_reg[10][3:2];
	assign o_input_clock_sel     = cfg_reg[10][4];
	assign o_input_signal_source = cfg_reg[11][7:6];
	assign o_power_down          = cfg_reg[12][6];

	// Nonvolatile copy: one byte per cycle, then programming wait
	assign nvm_go = i_nvm_start && !nvm_busy_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			nvm_busy_reg  <= 1'b0;
			nvm_copy_reg  <= 1'b0;
			nvm_idx_reg   <= 7'h00;
			nvm_wait_reg  <= 16'h0000;
			nvm_wr_en_reg <= 1'b0;
			nvm_addr_reg  <= 7'h00;
			nvm_data_reg  <= 8'h00;
		end
		else
		begin
			nvm_wr_en_reg <= 1'b0;
			if (nvm_go)
			begin
				nvm_busy_reg <= 1'b1;
				nvm_copy_reg <= 1'b1;
				nvm_idx_reg  <= 7'h00;
				nvm_wait_reg <= NVM_PROG_CNT;
			end
			else if (nvm_copy_reg)
			begin
				nvm_wr_en_reg <= 1'b1;
				nvm_addr_reg  <= nvm_idx_reg;
				nvm_data_reg  <= rd_byte(nvm_idx_reg);
				nvm_idx_reg   <= nvm_idx_reg + 7'h1;
				if (nvm_idx_reg == 7'(NVM_BYTES - 1))
					nvm_copy_reg <= 1'b0;
			end
			else if (nvm_busy_reg)
			begin
				if (nvm_wait_reg == 16'h0001)
					nvm_busy_reg <= 1'b0;
				nvm_wait_reg <= nvm_wait_reg - 16'h0001;
			end
		end
	end

	assign o_nvm_wr_en             = nvm_wr_en_reg;
	assign o_nvm_wr_addr           = nvm_addr_reg;
	assign o_nvm_wr_data           = nvm_data_reg;
	assign o_nvm_write_in_progress = nvm_busy_reg;

	// Checks
	sequence s_addr_byte;
		byte_done && phase_reg == PH_ADDR;
	endsequence

	sequence s_data_write;
		wr_fire;
	endsequence

	a_addr_ack: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_addr_byte and addr_hit |=> sda_oe_reg && st_reg == S_RX_ACK)
		else $error("Matching address not acknowledged");

	a_addr_ignore: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_addr_byte and (shift_reg[7:1] != own_addr) |=> !sda_oe_reg && st_reg == S_IDLE)
		else $error("Foreign address acknowledged");

	a_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_data_write and ptr_reg == OFS_POST1_CFG |=> cfg_reg[10] == $past(shift_reg))
		else $error("Written byte not stored at acknowledge");

	a_block_step: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_data_write and !single_reg |=> ptr_reg == $past(ptr_reg) + 7'h1)
		else $error("Block pointer did not advance");

	a_single_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_data_write and single_reg |=> $stable(ptr_reg) ##1 (!wr_fire)[*2])
		else $error("Single write moved the pointer");

	a_busy_span: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		nvm_go |=> nvm_busy_reg[*8])
		else $error("Busy flag dropped during programming");

	a_copy_first: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		nvm_go |=> ##1 o_nvm_wr_en && o_nvm_wr_addr == 7'h00 && o_nvm_wr_data == {REVISION, VENDOR_ID})
		else $error("Copy did not start at byte zero");

	a_no_busy_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		nvm_busy_reg && byte_done && phase_reg == PH_DATA && !rw_reg |=> !sda_oe_reg)
		else $error("Write acknowledged while programming");

	a_read_busy: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		s_addr_byte and addr_hit && nvm_busy_reg |=> sda_oe_reg)
		else $error("Read refused while programming");

	a_stop_release: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		stop_det |=> st_reg == S_IDLE && !sda_oe_reg)
		else $error("Stop did not release the bus");

endmodule : smbcfg_target
`default_nettype wire

// ### smbus_config_target_tb.sv
// Self-checking bench for the SMBus configuration target
`timescale 1ns/1ps
`default_nettype none
module smbus_config_target_tb;
	import smbcfg_pkg::*;
	localparam logic [7:0] ID_BYTE = 8'h05;  // Arbitrary revision and vendor
	logic			core_clk;
	logic			rstn;
	logic			nvm_start;
	logic			scl;
	logic			host_oe;
	logic			dev_oe;
	logic			dev_do;
	wire logic		sda;
	logic			nvm_wr_en;
	logic [6:0]		nvm_wr_addr;
	logic [7:0]		nvm_wr_data;
	logic			nvm_busy;
	logic [8:0]		ref1, ref2, ref3;
	logic [11:0]		fb1, fb2, fb3;
	logic [2:0]		mux_sel, vco_sel;
	logic [5:0][2:0]	post_src;
	logic [1:0]		cfg0, cfg1, in_src;
	logic			clk_sel, pwr_dn, ack_bit, exp_busy;
	logic [7:0]		bank [0:12];
	logic [7:0]		nvm_copy [0:12];
	logic [7:0]		wbuf [0:3];
	logic [6:0]		dev_addr;
	int			errors, cmp_count;

	assign sda = (dev_oe ? dev_do : 1'b1) & ~host_oe;

	smbcfg_target #(.REVISION(ID_BYTE[7:4]), .VENDOR_ID(ID_BYTE[3:0])) dut
	(
		.i_core_clk(core_clk),
		.i_rstn(rstn),
		.i_serial_clk_pin(scl),
		.i_serial_data_pin(sda),
		.o_serial_data_pin(dev_do),
		.o_serial_data_pin_oe(dev_oe),
		.i_nvm_start(nvm_start),
		.o_nvm_wr_en(nvm_wr_en),
		.o_nvm_wr_addr(nvm_wr_addr),
		.o_nvm_wr_data(nvm_wr_data),
		.o_nvm_write_in_progress(nvm_busy),
		.o_pll1_ref_div(ref1),
		.o_pll2_ref_div(ref2),
		.o_pll3_ref_div(ref3),
		.o_pll1_fb_div(fb1),
		.o_pll2_fb_div(fb2),
		.o_pll3_fb_div(fb3),
		.o_pll_mux_sel(mux_sel),
		.o_vco_range_sel(vco_sel),
		.o_post_source(post_src),
		.o_config_input_zero(cfg0),
		.o_config_input_one(cfg1),
		.o_input_clock_sel(clk_sel),
		.o_input_signal_source(in_src),
		.o_power_down(pwr_dn)
	);

	smbcfg_host_model host
	(
		.i_core_clk(core_clk),
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_oe(host_oe)
	);

	task finish_test();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task chk_val(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task chk_ack(input logic got, input logic exp);
		chk_val(20'(got), 20'(exp));
	endtask : chk_ack

	function automatic logic [7:0] exp_byte(input int o);
		if (o <= LAST_CFG)
			return bank[o];
		return (o == 24) ? {exp_busy, 7'h00} : 8'h00;
	endfunction : exp_byte

	task addr_cmd(input logic [7:0] cmd);
		host.start_cond();
		host.send_byte({dev_addr, 1'b0}, ack_bit);
		chk_ack(ack_bit, 1'b1);
		host.send_byte(cmd, ack_bit);
		chk_ack(ack_bit, 1'b1);
	endtask : addr_cmd

	task smb_write(input logic [7:0] cmd, input int n, input logic do_stop);
		addr_cmd(cmd);
		if (!cmd[7])
		begin
			host.send_byte(8'(n), ack_bit);
			chk_ack(ack_bit, 1'b1);
		end
		for (int i = 0; i < n; i++)
		begin
			host.send_byte(wbuf[i], ack_bit);
			chk_ack(ack_bit, 1'b1);
		end
		if (do_stop)
			host.stop_cond();
	endtask : smb_write

	task smb_read(input logic [7:0] cmd, input int n);
		logic [7:0] d;
		addr_cmd(cmd);
		host.start_cond();
		host.send_byte({dev_addr, 1'b1}, ack_bit);
		chk_ack(ack_bit, 1'b1);
		if (!cmd[7])
		begin
			host.recv_byte(1'b0, d);
			chk_val(20'(d), 20'h0_000d);
		end
		for (int i = 0; i < n; i++)
		begin
			host.recv_byte(i == n - 1, d);
			chk_val(20'(d), 20'(exp_byte(cmd[6:0] + i)));
		end
		host.stop_cond();
	endtask : smb_read

	task probe(input logic [6:0] a);
		host.start_cond();
		host.send_byte({a, 1'b0}, ack_bit);
		chk_ack(ack_bit, 1'b0);
		host.stop_cond();
	endtask : probe

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (50000) @(posedge core_clk);
		errors++;
		finish_test();
	end

	always @(posedge core_clk)
		if (nvm_wr_en === 1'b1)
			nvm_copy[nvm_wr_addr] <= nvm_wr_data;

	initial
	begin
		rstn = 1'b0;
		nvm_start = 1'b0;
		errors = 0;
		cmp_count = 0;
		exp_busy = 1'b0;
		dev_addr = 7'h69;
		bank = '{ID_BYTE, RST_PLL1_REF, RST_PLL1_FB, RST_MUX_PLL1_HI, RST_PLL2_REF, RST_PLL2_FB,
			RST_VCO_PLL2_HI, RST_PLL3_REF, RST_PLL3_FB, RST_POST0_HI, RST_POST1_CFG, RST_SRC_POST23, RST_PD_POST45};
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		// Defaults on outputs and in the bank
		chk_val(20'(ref1), 20'h0_0001);
		chk_val(20'(ref2), 20'h0_001b);
		chk_val(20'(ref3), 20'h0_0177);
		chk_val(20'(fb1), 20'h0_0008);
		chk_val(20'(fb3), 20'h0_0177);
		chk_val(20'(fb2), 20'h0_001b);
		chk_val(20'(vco_sel), 20'h0_0000);
		smb_read(8'h00, 13);
		$display("test defaults done");
		// Single write takes effect at its acknowledge, next byte refused
		wbuf[0] = 8'hb5;
		smb_write(8'h83, 1, 1'b0);
		chk_val(20'(fb1), 20'h0_0a08);
		chk_val(20'(ref1), 20'h0_0101);
		chk_val(20'(mux_sel), 20'h0_0005);
		host.send_byte(8'h3c, ack_bit);
		chk_ack(ack_bit, 1'b0);
		host.stop_cond();
		bank[3] = 8'hb5;
		smb_read(8'h83, 1);
		smb_read(8'h84, 1);
		$display("test single done");
		// Block write moves the address, slow host reads back early
		wbuf = '{8'he3, 8'hd4, 8'h9a, 8'hff};
		smb_write(8'h09, 4, 1'b1);
		chk_val(20'(post_src), 20'h3_f6b7);
		chk_val(20'({in_src, pwr_dn, clk_sel, cfg1, cfg0}), 20'h0_00b4);
		for (int i = 0; i < 4; i++)
			bank[9 + i] = wbuf[i];
		bank[12][7] = 1'b0;
		probe(7'h69);
		probe(7'h4a);
		dev_addr = 7'h6a;
		host.slow_cycles = 12;
		smb_read(8'h09, 4);
		host.slow_cycles = 0;
		$display("test block done");
		// Nonvolatile copy of the bank; byte 0 was never written
		nvm_start = 1'b1;
		@(negedge core_clk);
		nvm_start = 1'b0;
		@(negedge core_clk);
		chk_val(20'(nvm_busy), 20'h0_0001);
		exp_busy = 1'b1;
		smb_read(8'h98, 1);
		// No writes until programming ends
		for (int k = 0; k < 3000 && nvm_busy !== 1'b0; k++)
			@(negedge core_clk);
		chk_val(20'(nvm_busy), 20'h0_0000);
		exp_busy = 1'b0;
		for (int i = 0; i <= LAST_CFG; i++)
			chk_val(20'(nvm_copy[i]), 20'(bank[i]));
		smb_read(8'h98, 1);
		$display("test nvm done");
		finish_test();
	end
endmodule : smbus_config_target_tb
`default_nettype wire
